//--- dsw_defs.vh
// dsw_defs.vh: register offsets, field positions, reset values and sizes for the
// 16 kbit/s d-channel switch.
// assumes: included by its bare name from the design files.
`ifndef DSW_DEFS_VH
`define DSW_DEFS_VH

// register byte offsets (low address byte is decoded)
`define DSW_ROUTE_OFS      8'h00
`define DSW_DEST_OFS       8'h04
`define DSW_STATUS_OFS     8'h08

// route register fields
`define DSW_GRP_LO_BIT     0
`define DSW_GRP_HI_BIT     1
`define DSW_DS_EN_BIT      2
`define DSW_ORDER_BIT      3
`define DSW_SRC_LO_BIT     4
`define DSW_SRC_HI_BIT     5
`define DSW_ROUTE_W        6
`define DSW_ROUTE_RST      6'h00

// destination register fields
`define DSW_TS_LSB         0
`define DSW_TS_W           5
`define DSW_TDM_LSB        5
`define DSW_TDM_W          3
`define DSW_BID_BIT        8
`define DSW_DEST_W         9
`define DSW_DEST_RST       9'h000

// status register fields
`define DSW_ST_UP_BIT      0
`define DSW_ST_DS_BIT      1
`define DSW_ST_OVF_BIT     2
`define DSW_ST_CNT_LSB     8

// source select code that routes gci d channels
`define DSW_SRC_GCI        2'h2

// fifo sizes
`define DSW_FIFO_DEPTH     8
`define DSW_FIFO_WIDTH     16

`endif

//--- dsw_fifo.v
// dsw_fifo.v: synchronous fifo with valid/ready on both sides and a level count.
// assumes: one clock, asynchronous active-low reset, depth a power of two.
`timescale 1ns/1ps
module dsw_fifo #(
	parameter WIDTH = 16,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	// clock and reset
	input  wire             hclk,
	input  wire             hresetn,
	// fill side
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	// drain side
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data,
	// level
	output wire [AW:0]      count
);
	reg  [WIDTH-1:0] mem [0:DEPTH-1];
	reg  [AW:0]      wr_ptr_r;
	reg  [AW:0]      rd_ptr_r;
	wire             push;
	wire             pop;

	assign count     = wr_ptr_r - rd_ptr_r;
	assign in_ready  = (count != DEPTH[AW:0]);
	assign out_valid = (count != {(AW+1){1'b0}});
	assign out_data  = mem[rd_ptr_r[AW-1:0]];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always @(posedge hclk) begin
		if (push) begin
			mem[wr_ptr_r[AW-1:0]] <= in_data;
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ptr_r <= {(AW+1){1'b0}};
			rd_ptr_r <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
		end
	end
endmodule // dsw_fifo

//--- dsw_gci_model.sv
// dsw_gci_model.sv: gci line side and upstream drain model.
// assumes: driven by the bench through its frame task and hold flag.
`timescale 1ns/1ps
module dsw_gci_model (
	// clock
	input wire logic         hclk,
	// gci pins
	output logic             gci_frame_sync,
	output logic [15:0]      gci_input_mux_a,
	output logic [15:0]      gci_input_mux_b,
	// upstream drain
	output logic             up_ready
);
	logic   hold = 1'h0;
	integer seed = 32'hE5B6;
	integer r;
	initial begin
		gci_frame_sync = 1'h0;
		gci_input_mux_a = 16'h0;
		gci_input_mux_b = 16'h0;
		up_ready = 1'h0;
	end
	// drain stalls at random, or fully while hold is set
	always @(posedge hclk) begin
		r = $random(seed);
		up_ready <= !hold && r[0];
	end
	task frame(input logic [15:0] a, input logic [15:0] b);
		@(posedge hclk);
		gci_input_mux_a <= a;
		gci_input_mux_b <= b;
		repeat (3) @(posedge hclk);
		gci_frame_sync <= 1'h1;
		repeat (4) @(posedge hclk);
		gci_frame_sync <= 1'h0;
		repeat (3) @(posedge hclk);
		gci_input_mux_a <= ~a;
		gci_input_mux_b <= ~b;
	endtask
endmodule // dsw_gci_model

//--- dsw_switch.v
// dsw_switch.v: d-channel 16 kbit/s switch with an ahb-lite register slave.
// assumes: gci pins are asynchronous and are synchronised here; the downstream slot
// stream and the upstream drain are logic on hclk.
//
// How it works
// [R1] group 00 packs channels 0..3 of gci input mux a upstream
// [R2] group 01 packs channels 4..7 of gci input mux a upstream
// [R3] group 10 packs channels 0..3 of gci input mux b upstream
// [R4] group 11 packs channels 4..7 of gci input mux b upstream
// [R5] packed byte goes out tagged with destination timeslot and tdm
// [R6] lowest channel in bits 1/2, then 3/4, 5/6, highest 7/8
// [R7] downstream takes input slot equal to output slot, into paired output mux
// [R8] downstream bits 1/2 to lowest channel, up to 7/8 to highest
// [R9] source code 10 selects the gci d-channel routing
// [R10] downstream set up only with auto enable at 1, bidirectional flag zero
// [R11] software releases downstream by writing code 10 with enable zero
//
// Decided for this implementation: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "dsw_defs.vh"
module dsw_switch #(
	parameter FIFO_DEPTH = `DSW_FIFO_DEPTH,
	parameter FIFO_AW    = 3
) (
	// clock and reset
	input  wire        hclk,
	input  wire        hresetn,
	// ahb-lite slave
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg         hreadyout,
	output reg  [31:0] hrdata,
	output reg         hresp,
	// gci line side
	input  wire        gci_frame_sync,
	input  wire [15:0] gci_input_mux_a,
	input  wire [15:0] gci_input_mux_b,
	output reg  [15:0] gci_output_mux_a,
	output reg  [15:0] gci_output_mux_b,
	// downstream tdm slot stream
	input  wire        ds_slot_valid,
	input  wire [4:0]  ds_slot_num,
	input  wire [7:0]  ds_slot_data,
	// upstream tdm output
	output reg         up_valid,
	input  wire        up_ready,
	output reg  [4:0]  up_slot,
	output reg  [2:0]  up_tdm,
	output reg  [7:0]  up_data
);
	// registers
	reg  [`DSW_ROUTE_W-1:0] route_r;
	reg  [`DSW_ROUTE_W-1:0] route_nxt;
	reg  [`DSW_DEST_W-1:0]  dest_r;
	reg  [`DSW_DEST_W-1:0]  dest_nxt;
	reg                     ovf_r;
	reg                     ovf_nxt;
	reg                     ds_active_r;
	reg                     ds_active_nxt;
	// ahb data phase
	reg                     wr_pend_r;
	reg  [7:0]              addr_r;
	reg  [31:0]             rdata_nxt;
	// synchronisers
	reg                     fs_s1_r;
	reg                     fs_s2_r;
	reg                     fs_s3_r;
	reg  [15:0]             mux_a_s1_r;
	reg  [15:0]             mux_a_s2_r;
	reg  [15:0]             mux_b_s1_r;
	reg  [15:0]             mux_b_s2_r;
	// datapath
	wire                    frame_edge;
	wire [1:0]              src_sel;
	wire                    grp_lo;
	wire                    grp_hi;
	wire                    up_active;
	wire [15:0]             sel_mux;
	wire [7:0]              grp_vec;
	wire [7:0]              up_byte;
	wire [7:0]              ds_vec;
	wire                    ds_hit;
	wire                    push;
	wire                    fifo_in_ready;
	wire                    fifo_out_valid;
	wire                    fifo_out_ready;
	wire [15:0]             fifo_out_data;
	wire [FIFO_AW:0]        fifo_count;
	wire [15:0]             ds_merge_a;
	wire [15:0]             ds_merge_b;
	wire                    addr_ph;

	assign src_sel   = {route_r[`DSW_SRC_HI_BIT], route_r[`DSW_SRC_LO_BIT]};
	assign grp_lo    = route_r[`DSW_GRP_LO_BIT];
	assign grp_hi    = route_r[`DSW_GRP_HI_BIT];
	assign up_active = (src_sel == `DSW_SRC_GCI); // see [R9]

	// ahb-lite register slave
	assign addr_ph = hsel && hready && htrans[1];

	always @* begin
		route_nxt = route_r;
		dest_nxt  = dest_r;
		if (wr_pend_r && (addr_r == `DSW_ROUTE_OFS)) begin
			route_nxt = hwdata[`DSW_ROUTE_W-1:0];
		end
		if (wr_pend_r && (addr_r == `DSW_DEST_OFS)) begin
			dest_nxt = hwdata[`DSW_DEST_W-1:0];
		end
	end

	always @* begin
		ovf_nxt = ovf_r;
		if (wr_pend_r && (addr_r == `DSW_STATUS_OFS) && hwdata[`DSW_ST_OVF_BIT]) begin
			ovf_nxt = 1'b0;
		end
		if (push && !fifo_in_ready) begin
			ovf_nxt = 1'b1;
		end
	end

	always @* begin
		ds_active_nxt = ds_active_r;
		if (up_active) begin
			// see [R10] see [R11]
			ds_active_nxt = route_r[`DSW_DS_EN_BIT] && !dest_r[`DSW_BID_BIT];
		end
	end

	always @* begin
		rdata_nxt = 32'h00000000;
		case (haddr[7:0])
		`DSW_ROUTE_OFS: begin
			rdata_nxt[`DSW_ROUTE_W-1:0] = route_nxt;
		end
		`DSW_DEST_OFS: begin
			rdata_nxt[`DSW_DEST_W-1:0] = dest_nxt;
		end
		`DSW_STATUS_OFS: begin
			rdata_nxt[`DSW_ST_UP_BIT]  = up_active;
			rdata_nxt[`DSW_ST_DS_BIT]  = ds_active_r;
			rdata_nxt[`DSW_ST_OVF_BIT] = ovf_r;
			rdata_nxt[`DSW_ST_CNT_LSB+FIFO_AW:`DSW_ST_CNT_LSB] = fifo_count;
		end
		default: begin
			rdata_nxt = 32'h00000000;
		end
		endcase
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout   <= 1'b1;
			hresp       <= 1'b0;
			hrdata      <= 32'h00000000;
			wr_pend_r   <= 1'b0;
			addr_r      <= 8'h00;
			route_r     <= `DSW_ROUTE_RST;
			dest_r      <= `DSW_DEST_RST;
			ovf_r       <= 1'b0;
			ds_active_r <= 1'b0;
		end else begin
			hreadyout   <= 1'b1;
			hresp       <= 1'b0;
			wr_pend_r   <= addr_ph && hwrite;
			route_r     <= route_nxt;
			dest_r      <= dest_nxt;
			ovf_r       <= ovf_nxt;
			ds_active_r <= ds_active_nxt;
			if (addr_ph) begin
				addr_r <= haddr[7:0];
			end
			if (addr_ph && !hwrite) begin
				hrdata <= rdata_nxt;
			end
		end
	end

	// gci pin synchronisers
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fs_s1_r    <= 1'b0;
			fs_s2_r    <= 1'b0;
			fs_s3_r    <= 1'b0;
			mux_a_s1_r <= 16'h0000;
			mux_a_s2_r <= 16'h0000;
			mux_b_s1_r <= 16'h0000;
			mux_b_s2_r <= 16'h0000;
		end else begin
			fs_s1_r    <= gci_frame_sync;
			fs_s2_r    <= fs_s1_r;
			fs_s3_r    <= fs_s2_r;
			mux_a_s1_r <= gci_input_mux_a;
			mux_a_s2_r <= mux_a_s1_r;
			mux_b_s1_r <= gci_input_mux_b;
			mux_b_s2_r <= mux_b_s1_r;
		end
	end

	assign frame_edge = fs_s2_r && !fs_s3_r;

	// upstream group selection
	assign sel_mux = grp_hi ? mux_b_s2_r : mux_a_s2_r; // see [R1] see [R2] see [R3] see [R4]
	assign grp_vec = grp_lo ? sel_mux[15:8] : sel_mux[7:0]; // see [R1] see [R2] see [R3] see [R4]

	// per-channel packing and unpacking, bit 1 is the byte msb
	genvar k;
	generate
		for (k = 0; k < 4; k = k + 1) begin : g_chan
			assign up_byte[7-2*k -: 2]  = grp_vec[2*k+1 -: 2]; // see [R6]
			assign ds_vec[2*k+1 -: 2]   = ds_slot_data[7-2*k -: 2]; // see [R8]
		end
	endgenerate

	// upstream fifo
	assign push = frame_edge && up_active; // see [R9]

	dsw_fifo #(
		.WIDTH (`DSW_FIFO_WIDTH),
		.DEPTH (FIFO_DEPTH),
		.AW    (FIFO_AW)
	) u_fifo (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.in_valid  (push),
		.in_ready  (fifo_in_ready),
		.in_data   ({dest_r[`DSW_TDM_LSB +: `DSW_TDM_W], dest_r[`DSW_TS_LSB +: `DSW_TS_W],
		              up_byte}),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (fifo_out_data),
		.count     (fifo_count)
	);

	assign fifo_out_ready = !up_valid || up_ready;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			up_valid <= 1'b0;
			up_slot  <= 5'h00;
			up_tdm   <= 3'h0;
			up_data  <= 8'h00;
		end else if (fifo_out_ready) begin
			up_valid <= fifo_out_valid;
			if (fifo_out_valid) begin
				up_tdm  <= fifo_out_data[15:13]; // see [R5]
				up_slot <= fifo_out_data[12:8]; // see [R5]
				up_data <= fifo_out_data[7:0];
			end
		end
	end

	// downstream: slot number equal to the output slot, into the paired output mux
	assign ds_hit = ds_slot_valid && ds_active_r &&
	                (ds_slot_num == dest_r[`DSW_TS_LSB +: `DSW_TS_W]); // see [R7] see [R10]

	assign ds_merge_a = grp_lo ? {ds_vec, gci_output_mux_a[7:0]} :
	                             {gci_output_mux_a[15:8], ds_vec};
	assign ds_merge_b = grp_lo ? {ds_vec, gci_output_mux_b[7:0]} :
	                             {gci_output_mux_b[15:8], ds_vec};

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			gci_output_mux_a <= 16'h0000;
			gci_output_mux_b <= 16'h0000;
		end else if (ds_hit) begin
			if (grp_hi) begin
				gci_output_mux_b <= ds_merge_b; // see [R7]
			end else begin
				gci_output_mux_a <= ds_merge_a; // see [R7]
			end
		end
	end
endmodule // dsw_switch

//--- dsw_switch_asserts.sv
// dsw_switch_asserts.sv: port checker bound to dsw_switch.
// assumes: one clock hclk, asynchronous active-low reset hresetn.
`timescale 1ns/1ps
module dsw_switch_asserts (
	// clock and reset
	input wire logic        hclk,
	input wire logic        hresetn,
	// watched ports
	input wire logic        ds_slot_valid,
	input wire logic        up_valid,
	input wire logic        up_ready,
	input wire logic [4:0]  up_slot,
	input wire logic [2:0]  up_tdm,
	input wire logic [7:0]  up_data,
	input wire logic [15:0] gci_output_mux_a,
	input wire logic [15:0] gci_output_mux_b
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	chk_up_held: assert property (up_valid && !up_ready |=> up_valid)
		else $error("upstream word dropped");
	chk_up_byte_stable: assert property (up_valid && !up_ready |=> $stable(up_data))
		else $error("upstream byte moved");
	chk_up_dest_stable: assert property (up_valid && !up_ready |=> $stable({up_tdm, up_slot}))
		else $error("upstream destination moved");
	chk_mux_a_cause: assert property ($changed(gci_output_mux_a) |-> $past(ds_slot_valid))
		else $error("mux a changed without slot");
	chk_mux_b_cause: assert property ($changed(gci_output_mux_b) |-> $past(ds_slot_valid))
		else $error("mux b changed without slot");
	chk_one_mux_only: assert property (!($changed(gci_output_mux_a) && $changed(gci_output_mux_b)))
		else $error("both muxes changed");
	chk_half_a_only: assert property ($changed(gci_output_mux_a) |->
		$stable(gci_output_mux_a[15:8]) || $stable(gci_output_mux_a[7:0]))
		else $error("mux a both groups changed");
	chk_half_b_only: assert property ($changed(gci_output_mux_b) |->
		$stable(gci_output_mux_b[15:8]) || $stable(gci_output_mux_b[7:0]))
		else $error("mux b both groups changed");
endmodule // dsw_switch_asserts
bind dsw_switch dsw_switch_asserts i_dsw_switch_asserts (.hclk(hclk), .hresetn(hresetn),
	.ds_slot_valid(ds_slot_valid), .up_valid(up_valid), .up_ready(up_ready),
	.up_slot(up_slot), .up_tdm(up_tdm), .up_data(up_data),
	.gci_output_mux_a(gci_output_mux_a), .gci_output_mux_b(gci_output_mux_b));

//--- test_d_channel_sixteen_kbit_switch.sv
// test_d_channel_sixteen_kbit_switch.sv: self-checking bench for dsw_switch.
// assumes: dsw_gci_model and the bound checker are compiled before it.
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin miscompares++; \
	$display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module test_d_channel_sixteen_kbit_switch;
	logic        hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, dv = 1'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, ex = 32'h0, k;
	logic [1:0]  htrans = 2'h0;
	logic [4:0]  dn = 5'h0;
	logic [7:0]  dd = 8'h0;
	logic [15:0] q[$], w, a, b;
	wire         hready, fs, uv, ur, hr;
	wire  [31:0] hrdata;
	wire  [15:0] ma, mb, oa, ob;
	wire  [4:0]  us;
	wire  [2:0]  ut;
	wire  [7:0]  ud;
	integer      miscompares = 0, comparisons = 0, seed = 32'hE5B6, g;
	always #12.5 hclk = ~hclk;
	dsw_switch i_dsw_switch (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
		.hreadyout(hready), .hrdata(hrdata), .hresp(hr), .gci_frame_sync(fs),
		.gci_input_mux_a(ma), .gci_input_mux_b(mb), .gci_output_mux_a(oa),
		.gci_output_mux_b(ob), .ds_slot_valid(dv), .ds_slot_num(dn), .ds_slot_data(dd),
		.up_valid(uv), .up_ready(ur), .up_slot(us), .up_tdm(ut), .up_data(ud));
	dsw_gci_model i_dsw_gci_model (.hclk(hclk), .gci_frame_sync(fs), .gci_input_mux_a(ma),
		.gci_input_mux_b(mb), .up_ready(ur));
	function automatic logic [7:0] pk(input logic [15:0] m, input integer o);
		pk = {m[o+:2], m[o+2+:2], m[o+4+:2], m[o+6+:2]};
	endfunction
	task ahb(input logic wr, input logic [31:0] ad, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'h1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= ad;
		do @(posedge hclk); while (hready !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'h1);
		rd = hrdata;
	endtask
	task ds(input logic [4:0] n, input logic [7:0] d);
		@(posedge hclk);
		dv <= 1'h1;
		dn <= n;
		dd <= d;
		@(posedge hclk);
		dv <= 1'h0;
		dn <= ~n;
		dd <= ~d;
		#1;
	endtask
	task test_done;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// monitor: each word taken upstream is matched against the oldest note
	always @(posedge hclk) if (uv === 1'h1 && ur === 1'h1) begin
		w = q.size() ? q.pop_front() : 16'hXXXX;
		`CHK("upstream word", w, {ut, us, ud})
	end
	initial begin
		#600000;
		miscompares++;
		test_done;
	end
	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'h1;
		ahb(1'h0, 32'h40, 32'h0);
		`CHK("unmapped", 33'h0, {hr, rd})
		for (g = 0; g < 4; g++) begin
			k = $random(seed);
			ahb(1'h1, 32'h04, {27'h0, k[4:0]});
			ahb(1'h1, 32'h00, 32'h24 | g);
			ds(k[4:0] ^ 5'h1, k[15:8]);
			ds(k[4:0], k[23:16]);
			ex[g*8+:8] = pk({8'h0, k[23:16]}, 0);
			`CHK("out muxes", ex, {ob, oa})
			ahb(1'h1, 32'h00, 32'h20 | g);
			ds(k[4:0], ~k[23:16]);
			`CHK("released", ex, {ob, oa})
		end
		ahb(1'h1, 32'h04, {23'h0, 9'h100 | k[4:0]});
		ahb(1'h1, 32'h00, 32'h27);
		ds(k[4:0], k[31:24]);
		`CHK("bidir set", ex, {ob, oa})
		for (g = 0; g < 4; g++) begin
			k = $random(seed);
			ahb(1'h1, 32'h04, {24'h0, k[7:0]});
			ahb(1'h1, 32'h00, 32'h20 | g);
			ahb(1'h0, 32'h00, 32'h0);
			`CHK("route", 32'h20 | g, rd)
			a = $random(seed);
			b = $random(seed);
			q.push_back({k[7:0], pk(g[1] ? b : a, g[0] ? 8 : 0)});
			i_dsw_gci_model.frame(a, b);
		end
		while (q.size() != 0) @(posedge hclk);
		i_dsw_gci_model.hold <= 1'h1;
		repeat (10) begin
			b = $random(seed);
			if (q.size() < 9) q.push_back({k[7:0], pk(b, 8)});
			i_dsw_gci_model.frame(~b, b);
		end
		ahb(1'h0, 32'h08, 32'h0);
		`CHK("status full", 32'h805, rd)
		i_dsw_gci_model.hold <= 1'h0;
		while (q.size() != 0) @(posedge hclk);
		repeat (4) @(posedge hclk);
		// source code 01: no upstream word may appear, order bit only stored
		ahb(1'h1, 32'h00, 32'h1B);
		ahb(1'h0, 32'h00, 32'h0);
		`CHK("route other", 32'h1B, rd)
		b = $random(seed);
		i_dsw_gci_model.frame(b, ~b);
		repeat (8) @(posedge hclk);
		ahb(1'h0, 32'h08, 32'h0);
		`CHK("status other", 32'h004, rd)
		ahb(1'h1, 32'h08, 32'h4);
		ahb(1'h0, 32'h08, 32'h0);
		`CHK("status clear", 32'h0, rd)
		test_done;
	end
endmodule // test_d_channel_sixteen_kbit_switch
